// ===== src/tlm_handshake.sv
`timescale 1ns/1ns
// Contract
// - terminal publishes its request words on transmit subaddress 10
// - terminal evaluates confirmation by next sync, then prepares next packet
// - new packet and request loaded within 2 ms of subframe start
// - nothing pending: word one zero, count kept, flow control 00
// - burst mode uses 1024-octet packets and sets the burst bit
// - burst: request updated at own-address sync or first SA 11 access
// - burst: output buffers refreshed at confirmation or own-address sync
// - event: load SA 5 or 6 buffer, then set matching flag
// - controller copies event; terminal compares sent and copied signatures for taking
// - terminal checks event confirmation each sync, clears flag when confirmed
// - after clearing a flag, wait 2 subframes before setting again
// - flow codes: 00 none, 01 pending, 10 reserved, 11 controller only
// - packet count cycles 1..255, starts at 0 after reset or restart
module tlm_handshake
   import tlm_pkg::*;
#(
   parameter int LOAD_CYCLES = LOAD_CYC
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // bus core events
   input  wire bus_evt_t          bus_evt,
   input  wire logic [1:0][15:0]  evt_tx_sig,
   input  wire logic [1:0][15:0]  evt_rx_sig,
   // transmit SA 10 contents and buffer control
   output req_words_t             req_words,
   output logic                   pkt_load
);

   // ==========================================================
   // registers
   logic              burst_en_ff;
   logic              first_ff;
   logic              staged_ff;
   logic [15:0]       staged_w1_ff;
   logic [15:0]       w1_ff;
   logic [1:0]        flow_ff;
   logic [7:0]        cnt_ff;
   logic              burst_pub_ff;
   xfer_state_t       state_ff;
   logic              got_conf_ff;
   logic [15:0]       conf_w2_ff;
   logic              sa11_seen_ff;
   logic [17:0]       timer_ff;
   logic              pkt_load_ff;
   logic [1:0]        evt_flag_ff;
   logic [1:0]        evt_pend_ff;
   logic [1:0][1:0]   hold_ff;
   logic [31:0]       prdata_ff;

   // ==========================================================
   // functions
   function automatic logic [7:0] next_count(input logic [7:0] c, input logic first);
      logic [7:0] n;
      n = c + CNT_MIN;
      if (first) begin
         n = CNT_FIRST;
      end else if (c == CNT_MAX) begin
         n = CNT_MIN;
      end
      return n;
   endfunction

   // ==========================================================
   // apb decode
   wire        wr_en     = psel & penable & pwrite;
   wire        setup     = psel & ~penable;
   wire        hit_ctrl  = (paddr == ADDR_CTRL);
   wire        hit_req   = (paddr == ADDR_REQ);
   wire        hit_evt   = (paddr == ADDR_EVT);
   wire        hit_stat  = (paddr == ADDR_STAT);
   wire        hit_words = (paddr == ADDR_WORDS);
   wire        mapped    = hit_ctrl | hit_req | hit_evt | hit_stat | hit_words;
   wire        wr_ctrl   = wr_en & hit_ctrl;
   wire        wr_req    = wr_en & hit_req;
   wire [1:0]  wr_evt    = (wr_en & hit_evt) ? pwdata[1:0] : 2'h0;
   wire        restart   = wr_ctrl & pwdata[CTRL_RESTART_BIT];

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux = {31'h0, burst_en_ff};
      end else if (hit_req) begin
         rd_mux = {16'h0, staged_w1_ff};
      end else if (hit_evt) begin
         rd_mux = {26'h0, (hold_ff[1] != 2'h0), (hold_ff[0] != 2'h0), evt_pend_ff, evt_flag_ff};
      end else if (hit_stat) begin
         rd_mux = {16'h0, cnt_ff, 3'h0, got_conf_ff, staged_ff, first_ff, state_ff};
      end else if (hit_words) begin
         rd_mux = {req_words.w2, req_words.w1};
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup) begin
         prdata_ff <= rd_mux;
      end
   end

   // ==========================================================
   // subframe timing and triggers
   wire own_sync   = bus_evt.sync & bus_evt.addr_match;
   wire first_sa11 = bus_evt.sa11_access & ~sa11_seen_ff;
   wire in_window  = (timer_ff < LOAD_CYCLES[17:0]);
   wire burst_trig = own_sync | first_sa11;
   wire publish    = staged_ff & (burst_en_ff ? burst_trig
                                              : (state_ff == ST_IDLE) & in_window);
   wire conf_ok    = (conf_w2_ff[12:11] == FLOW_DONE) & (conf_w2_ff[7:0] == cnt_ff);
   wire confirmed  = bus_evt.sync & got_conf_ff & conf_ok;
   wire refresh    = burst_en_ff ? (bus_evt.conf_rx | own_sync) : confirmed;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_ff     <= 18'h0;
         sa11_seen_ff <= 1'b0;
      end else begin
         timer_ff     <= bus_evt.sync ? 18'h0 : (in_window ? timer_ff + 18'h1 : timer_ff);
         sa11_seen_ff <= ~bus_evt.sync & (sa11_seen_ff | bus_evt.sa11_access);
      end
   end

   // ==========================================================
   // software control and staging
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_en_ff  <= 1'b0;
         staged_ff    <= 1'b0;
         staged_w1_ff <= W1_RESET;
      end else begin
         if (wr_ctrl) begin
            burst_en_ff <= pwdata[CTRL_BURST_BIT];
         end
         if (wr_req) begin
            staged_w1_ff <= pwdata[15:0];
         end
         staged_ff <= wr_req | (staged_ff & ~(publish & ~restart));
      end
   end

   // ==========================================================
   // request words and transfer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w1_ff        <= W1_RESET;
         flow_ff      <= FLOW_NONE;
         cnt_ff       <= CNT_FIRST;
         first_ff     <= 1'b1;
         burst_pub_ff <= 1'b0;
         state_ff     <= ST_IDLE;
      end else if (restart) begin
         first_ff <= 1'b1;
         state_ff <= ST_IDLE;
      end else if (publish) begin
         w1_ff        <= burst_en_ff ? BURST_W1 : staged_w1_ff;
         flow_ff      <= FLOW_PEND;
         cnt_ff       <= next_count(cnt_ff, first_ff);
         first_ff     <= 1'b0;
         burst_pub_ff <= burst_en_ff;
         state_ff     <= ST_REQ;
      end else if (confirmed) begin
         state_ff <= ST_IDLE;
         if (!staged_ff) begin
            w1_ff   <= W1_RESET;
            flow_ff <= FLOW_NONE;
         end
      end else if (bus_evt.conf_rx && state_ff == ST_REQ) begin
         state_ff <= ST_CONF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         got_conf_ff <= 1'b0;
         conf_w2_ff  <= 16'h0;
         pkt_load_ff <= 1'b0;
      end else begin
         if (bus_evt.conf_rx) begin
            conf_w2_ff <= bus_evt.conf_w2;
         end
         got_conf_ff <= bus_evt.conf_rx | (got_conf_ff & ~bus_evt.sync);
         pkt_load_ff <= refresh;
      end
   end

   assign req_words.w1 = w1_ff;
   assign req_words.w2 = {evt_flag_ff[0], evt_flag_ff[1], burst_pub_ff, flow_ff, 3'h0, cnt_ff};
   assign pkt_load     = pkt_load_ff;

   // ==========================================================
   // event flags
   logic [1:0] evt_taken;
   logic [1:0] evt_set;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         evt_taken[i] = bus_evt.sync & evt_flag_ff[i] & (evt_tx_sig[i] == evt_rx_sig[i]);
         evt_set[i]   = evt_pend_ff[i] & ~evt_flag_ff[i] & (hold_ff[i] == 2'h0);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_flag_ff <= 2'h0;
         evt_pend_ff <= 2'h0;
         hold_ff     <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            evt_pend_ff[i] <= wr_evt[i] | (evt_pend_ff[i] & ~evt_set[i]);
            if (evt_taken[i]) begin
               evt_flag_ff[i] <= 1'b0;
               hold_ff[i]     <= EVT_HOLD_SF;
            end else begin
               if (evt_set[i]) begin
                  evt_flag_ff[i] <= 1'b1;
               end
               if (bus_evt.sync && hold_ff[i] != 2'h0) begin
                  hold_ff[i] <= hold_ff[i] - 2'h1;
               end
            end
         end
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_sync_confirm;
      bus_evt.sync && got_conf_ff && conf_ok && !restart && !publish;
   endsequence

   a_request_publish: assert property (publish && !restart |=> flow_ff == FLOW_PEND && state_ff == ST_REQ)
      else $error("request not published on SA 10");
   a_confirm_idle: assert property (s_sync_confirm |=> state_ff == ST_IDLE)
      else $error("confirmation at sync did not end transfer");
   a_load_window: assert property (publish && !burst_en_ff |-> timer_ff < LOAD_CYCLES[17:0])
      else $error("request loaded after 2 ms window");
   a_end_transfer: assert property ((s_sync_confirm and !staged_ff) |=> w1_ff == 16'h0 && flow_ff == FLOW_NONE
                                    && cnt_ff == $past(cnt_ff))
      else $error("end of transfer words wrong");
   a_burst_size: assert property (publish && burst_en_ff && !restart |=> w1_ff == BURST_W1 && req_words.w2[13])
      else $error("burst request not 1024 octets with burst bit");
   a_burst_update: assert property (publish && burst_en_ff |-> own_sync || (bus_evt.sa11_access && !sa11_seen_ff))
      else $error("burst request updated at wrong moment");
   a_burst_refresh: assert property (burst_en_ff && bus_evt.conf_rx |=> pkt_load)
      else $error("burst buffers not refreshed on confirmation");
   a_event_clear: assert property (evt_taken[0] |=> !evt_flag_ff[0] ##0 hold_ff[0] == 2'h2)
      else $error("confirmed event flag not cleared");
   // syncs seen since event b was last taken, saturating at the hold span
   logic [1:0] syncs_b_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         syncs_b_ff <= EVT_HOLD_SF;
      end else if (evt_taken[1]) begin
         syncs_b_ff <= 2'h0;
      end else if (bus_evt.sync && syncs_b_ff != EVT_HOLD_SF) begin
         syncs_b_ff <= syncs_b_ff + 2'h1;
      end
   end

   a_event_hold: assert property ($rose(evt_flag_ff[1]) |-> syncs_b_ff == EVT_HOLD_SF)
      else $error("event flag set again within 2 subframes");
   a_count_range: assert property (publish && !first_ff && !restart |=> cnt_ff != CNT_FIRST)
      else $error("packet count reached zero in normal operation");
   a_count_wrap: assert property (publish && !first_ff && !restart && cnt_ff == CNT_MAX
                                  |=> cnt_ff == CNT_MIN)
      else $error("packet count did not wrap to one");
   a_event_taken: assert property ($fell(evt_flag_ff[0]) |-> $past(bus_evt.sync)
                                   && $past(evt_tx_sig[0]) == $past(evt_rx_sig[0]))
      else $error("event flag cleared without matching copy");

endmodule

// ===== src/tlm_pkg.sv
package tlm_pkg;

   // ==========================================================
   // register map (byte addresses on the APB)
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_REQ   = 8'h04;
   localparam logic [7:0] ADDR_EVT   = 8'h08;
   localparam logic [7:0] ADDR_STAT  = 8'h0c;
   localparam logic [7:0] ADDR_WORDS = 8'h10;

   // ==========================================================
   // field positions and values
   localparam int         CTRL_BURST_BIT   = 0;
   localparam int         CTRL_RESTART_BIT = 1;
   localparam logic [1:0] FLOW_NONE        = 2'h0;
   localparam logic [1:0] FLOW_PEND        = 2'h1;
   localparam logic [1:0] FLOW_DONE        = 2'h3;
   localparam logic [7:0] CNT_FIRST        = 8'h00;
   localparam logic [7:0] CNT_MIN          = 8'h01;
   localparam logic [7:0] CNT_MAX          = 8'hff;
   // 1024 octets: 16 messages of 32 words, 32 coded as zero
   localparam logic [15:0] BURST_W1        = 16'h1000;
   localparam logic [15:0] W1_RESET        = 16'h0000;
   localparam logic [1:0]  EVT_HOLD_SF     = 2'h2;

   // ==========================================================
   // timing
   localparam int CLK_MHZ        = 125;
   localparam int LOAD_WINDOW_US = 2000;
   localparam int LOAD_CYC       = LOAD_WINDOW_US * CLK_MHZ;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REQ  = 2'b01,
      ST_CONF = 2'b11
   } xfer_state_t;

   typedef struct packed {
      logic        sync;         // synchronize mode command seen
      logic        addr_match;   // sync data word holds our address
      logic        sa11_access;  // controller read of transmit SA 11
      logic        conf_rx;      // confirmation written to receive SA 10
      logic [15:0] conf_w2;      // its second word
   } bus_evt_t;

   typedef struct packed {
      logic [15:0] w1;
      logic [15:0] w2;
   } req_words_t;

endpackage

// ===== dv/tlm_bc_model.sv
`timescale 1ns/1ns
module tlm_bc_model
   import tlm_pkg::*;
(
   // clock
   input  wire logic             pclk,
   // terminal side
   input  wire req_words_t       req_words,
   input  wire logic [1:0][15:0] evt_tx_sig,
   // controller traffic
   output bus_evt_t              bus_evt,
   output logic [1:0][15:0]      evt_rx_sig
);
   initial begin
      bus_evt         = '0;
      bus_evt.conf_w2 = 16'ha5a5;
      evt_rx_sig      = '0;
   end

   // ==========================================================
   // subframe start, optionally carrying our address
   task automatic subframe(input logic match);
      bus_evt.sync       <= 1'b1;
      bus_evt.addr_match <= match;
      @(posedge pclk);
      bus_evt.sync       <= 1'b0;
      bus_evt.addr_match <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic sa11();
      bus_evt.sa11_access <= 1'b1;
      @(posedge pclk);
      bus_evt.sa11_access <= 1'b0;
      @(posedge pclk);
   endtask

   // ==========================================================
   // poll the request, then confirm; skew makes a wrong count on command
   task automatic confirm(input logic [7:0] skew);
      logic [15:0] w2;
      logic [15:0] cw;
      w2 = req_words.w2;
      cw = {2'b00, w2[13], FLOW_DONE, 3'b000, w2[7:0] + skew};
      bus_evt.conf_w2 <= cw;
      bus_evt.conf_rx <= 1'b1;
      @(posedge pclk);
      bus_evt.conf_rx <= 1'b0;
      bus_evt.conf_w2 <= ~cw;
      @(posedge pclk);
   endtask

   // one copy of the event message per command
   task automatic copy_evt(input int k);
      evt_rx_sig[k] <= evt_tx_sig[k];
      @(posedge pclk);
   endtask
endmodule

// ===== dv/tlm_handshake_tb.sv
`timescale 1ns/1ns
module tlm_handshake_tb
   import tlm_pkg::*;
;
   logic             pclk;
   logic             presetn;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [7:0]       paddr;
   logic [31:0]      pwdata;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             pkt_load;
   bus_evt_t         bus_evt;
   logic [1:0][15:0] evt_tx_sig;
   logic [1:0][15:0] evt_rx_sig;
   req_words_t       req_words;
   logic [31:0]      rd;
   logic             err;
   logic [7:0]       cnt;
   int               n_mismatch;
   int               n_checks;
   int               n_load = 0;
   int               base;

   tlm_handshake #(.LOAD_CYCLES(50)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_evt(bus_evt), .evt_tx_sig(evt_tx_sig), .evt_rx_sig(evt_rx_sig), .req_words(req_words),
      .pkt_load(pkt_load));
   tlm_bc_model i_bc (.pclk(pclk), .req_words(req_words), .evt_tx_sig(evt_tx_sig), .bus_evt(bus_evt),
      .evt_rx_sig(evt_rx_sig));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) if (pkt_load === 1'b1) n_load <= n_load + 1;

   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic words();
      repeat (2) @(posedge pclk);
      apb(1'b0, ADDR_WORDS, 32'h0);
   endtask

   task automatic end_sim();
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      apb(1'b0, ADDR_WORDS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, 8'h20, 32'h0);
      chk({rd[30:0], err}, 32'h1);
   endtask

   task automatic t_nominal();
      cnt = CNT_FIRST;
      base = n_load;
      i_bc.subframe(1'b0);
      for (int i = 0; i < 257; i++) begin
         apb(1'b1, ADDR_REQ, 32'h0123);
         words();
         chk(rd, {3'b000, FLOW_PEND, 3'b000, cnt, 16'h0123});
         i_bc.confirm(8'h00);
         i_bc.subframe(1'b0);
         words();
         chk(rd, {3'b000, FLOW_NONE, 3'b000, cnt, W1_RESET});
         chk(n_load, base + i + 1);
         cnt = (cnt == CNT_MAX) ? CNT_MIN : cnt + 8'h01;
      end
   endtask

   task automatic t_window();
      i_bc.subframe(1'b0);
      repeat (60) @(posedge pclk);
      apb(1'b1, ADDR_REQ, 32'h0042);
      words();
      chk(rd, {3'b000, FLOW_NONE, 3'b000, 8'h01, W1_RESET});
      i_bc.subframe(1'b0);
      words();
      chk(rd, {3'b000, FLOW_PEND, 3'b000, cnt, 16'h0042});
      i_bc.confirm(8'h01);
      i_bc.subframe(1'b0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk({30'h0, rd[1:0]}, {30'h0, ST_CONF});
      i_bc.confirm(8'h00);
      i_bc.subframe(1'b0);
      cnt = cnt + 8'h01;
   endtask

   task automatic t_event();
      for (int k = 0; k < 2; k++) begin
         evt_tx_sig[k] <= ~evt_tx_sig[k];
         apb(1'b1, ADDR_EVT, 32'h1 << k);
         words();
         chk({31'h0, rd[31-k]}, 32'h1);
         i_bc.subframe(1'b0);
         words();
         chk({31'h0, rd[31-k]}, 32'h1);
         i_bc.copy_evt(k);
         i_bc.subframe(1'b0);
         words();
         chk({31'h0, rd[31-k]}, 32'h0);
         apb(1'b1, ADDR_EVT, 32'h1 << k);
         i_bc.subframe(1'b0);
         words();
         chk({31'h0, rd[31-k]}, 32'h0);
         i_bc.subframe(1'b0);
         words();
         chk({31'h0, rd[31-k]}, 32'h1);
      end
   endtask

   task automatic t_burst();
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_REQ, 32'h0055);
      i_bc.subframe(1'b0);
      words();
      chk(rd, {3'b000, FLOW_NONE, 3'b000, cnt - 8'h01, W1_RESET});
      i_bc.subframe(1'b1);
      words();
      chk(rd, {3'b001, FLOW_PEND, 3'b000, cnt, BURST_W1});
      base = n_load;
      i_bc.confirm(8'h00);
      i_bc.subframe(1'b0);
      chk(n_load, base + 1);
      cnt = cnt + 8'h01;
      apb(1'b1, ADDR_REQ, 32'h0066);
      i_bc.sa11();
      words();
      chk(rd, {3'b001, FLOW_PEND, 3'b000, cnt, BURST_W1});
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b1, ADDR_REQ, 32'h0077);
      i_bc.subframe(1'b0);
      words();
      chk(rd, {3'b000, FLOW_PEND, 3'b000, CNT_FIRST, 16'h0077});
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      presetn       = 1'b0;
      psel          = 1'b0;
      penable       = 1'b0;
      pwrite        = 1'b0;
      paddr         = 8'h00;
      pwdata        = 32'h0;
      evt_tx_sig[0] = 16'h1234;
      evt_tx_sig[1] = 16'h5678;
      n_mismatch    = 0;
      n_checks      = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_nominal();
      t_window();
      t_event();
      t_burst();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      end_sim();
   end
endmodule
